// ### common/ibts_consts.vh
// Purpose: Shared constants of the buffered I2C transfer sequencer.
// Assumes: Included by bare name from the design files.
// Notes: Offsets are byte addresses on the register bus.
`ifndef IBTS_CONSTS_VH
`define IBTS_CONSTS_VH

// Register byte offsets.
`define IBTS_OFS_STATUS 8'h00
`define IBTS_OFS_DATA 8'h04
`define IBTS_OFS_COUNT 8'h08
`define IBTS_OFS_CTRL 8'h0c
`define IBTS_OFS_OWNADR 8'h10

// Control, count and own address field positions.
`define IBTS_CTL_AA 7
`define IBTS_CTL_STA 5
`define IBTS_CTL_STO 4
`define IBTS_CTL_SI 3
`define IBTS_CTL_MODE 0
`define IBTS_CNT_LB 7
`define IBTS_OWN_GC 0

// Reset values.
`define IBTS_RST_STATUS 8'hf8
`define IBTS_RST_COUNT 8'h00
`define IBTS_RST_CTRL 8'h00
`define IBTS_RST_OWNADR 8'h00

// Status codes.
`define IBTS_ST_START 8'h08
`define IBTS_ST_RSTART 8'h10
`define IBTS_ST_MT_AACK 8'h18
`define IBTS_ST_MT_ANACK 8'h20
`define IBTS_ST_MT_DACK 8'h28
`define IBTS_ST_MT_DNACK 8'h30
`define IBTS_ST_ARB_LOST 8'h38
`define IBTS_ST_MR_ANACK 8'h48
`define IBTS_ST_MR_ACK 8'h50
`define IBTS_ST_MR_NACK 8'h58
`define IBTS_ST_SR_OWN 8'h60
`define IBTS_ST_SR_GC 8'h70
`define IBTS_ST_ST_OWN 8'ha8
`define IBTS_ST_ST_ARB 8'hb0
`define IBTS_ST_ST_ACK 8'hb8
`define IBTS_ST_ST_NACK 8'hc0
`define IBTS_ST_ST_LAST 8'hc8
`define IBTS_ST_IDLE 8'hf8

// Buffer size and timing.
`define IBTS_BUF_DEPTH 68
`define IBTS_T_HALF_NS 1250
`define IBTS_CLK_PERIOD_NS 50

`endif

// ### hw/ibts_buffer_mem.v
// Purpose: Byte buffer shared by the host data port and the serial engine.
// Assumes: One write and one read per clock; read data is registered.
// Notes: The array itself has no reset; only the read register does.
`include "ibts_consts.vh"

module ibts_buffer_mem #(
  parameter WIDTH = 8,
  parameter DEPTH = `IBTS_BUF_DEPTH,
  parameter AW = 7
) (
  input wire hclk,
  input wire hresetn,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [WIDTH-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [WIDTH-1:0] rdata
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // Write port, no reset so that the array maps onto plain storage.
  always @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata <= {WIDTH{1'b0}};
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

// ### hw/ibts_core.v
// Purpose: Buffered I2C master/slave transfer sequencer behind an AHB-Lite slave.
// Assumes: Pins are synchronous to hclk; single AHB slave; word accesses only.
// Notes: Open-drain pins are driven low when the enable (active low) is low.
// Functional notes
// - Own address with read acked posts A8h, then sends count after flag clear.
// - Slave batch begun with ack_enable clear sends count, then goes not addressed.
// - Lost arbitration then addressed for read enters slave transmit, posting B0h.
// - Master NACK posts C0h and releases bus; address matching follows enables.
// - Start requested when leaving C0h is issued once the bus becomes free.
// - The last-byte NACK flag only matters while receiving.
// - Buffer write pointer wraps past the 68th byte back to location zero.
// - Exactly the programmed count is sent; extra loaded bytes stay unsent.
// - Short loads still send the full count from whatever the buffer holds.
// - Master start request sends START, then sets flag, interrupt and status.
// - Control write with SI, start and stop clear after status read clears flag and resumes.
// - First byte after START is address plus direction, the rest are data.
// - Sequence end sets flag and interrupt, posts status, count reads bytes moved.
// - Batches chain until stop; a stop request ends the master session.
// - Master receive with last-byte NACK clear acks the batch's final byte.
// - Last-byte NACK set leaves the final received byte unacknowledged.
// - Posting any status except F8h after STOP sets the flag and pulls the interrupt output low.
// - With ack_enable clear the own address is ignored; matching resumes when set.
`include "ibts_consts.vh"

module ibts_core #(
  parameter BUF_DEPTH = `IBTS_BUF_DEPTH,
  parameter PTR_W = 7,
  parameter HALF_CYC = (`IBTS_T_HALF_NS + `IBTS_CLK_PERIOD_NS - 1) / `IBTS_CLK_PERIOD_NS
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  output wire int_n,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe_n,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_MSTART = 4'h1;
  localparam [3:0] ST_WAIT = 4'h2;
  localparam [3:0] ST_LD1 = 4'h3;
  localparam [3:0] ST_LD2 = 4'h4;
  localparam [3:0] ST_BIT = 4'h5;
  localparam [3:0] ST_MSTOP = 4'h6;
  // Timer reload, cut to the timer's width on purpose.
  localparam integer HALF_M1 = HALF_CYC - 1;
  localparam [15:0] HALF_LD = HALF_M1[15:0];

  // Wrapping buffer pointer step; no guard against overrunning a batch.
  function [PTR_W-1:0] ptr_inc;
    input [PTR_W-1:0] p;
    begin
      ptr_inc = (p == BUF_DEPTH - 1) ? {PTR_W{1'b0}} : p + 1'b1;
    end
  endfunction

  reg a_valid_reg, a_write_reg, rd_wait_reg;
  reg [7:0] a_addr_reg;
  reg [31:0] hrdata_reg;
  reg [7:0] status_reg, own_reg, shift_reg;
  reg si_reg, aa_reg, sta_reg, sto_reg, mode_reg, lb_reg;
  reg [6:0] bc_reg, cnt_reg;
  reg [PTR_W-1:0] hptr_reg, eptr_reg;
  reg [3:0] state_reg, bitcnt_reg;
  reg [1:0] ph_reg;
  reg [15:0] tmr_reg;
  reg nack_reg, sda_low_reg, scl_low_reg, master_reg, tx_reg, addr_ph_reg;
  reg arb_lost_reg, rxm_reg, drop_reg, rep_reg, busy_reg, scl_q, sda_q;
  wire [7:0] mem_rdata;

  // Bus slave strobes; every read takes one wait state for the buffer.
  wire host_wr = a_valid_reg & a_write_reg;
  wire rd_first = a_valid_reg & ~a_write_reg & ~rd_wait_reg;
  wire data_rd = a_valid_reg & ~a_write_reg & (a_addr_reg == `IBTS_OFS_DATA);
  wire data_wr = host_wr & (a_addr_reg == `IBTS_OFS_DATA);
  wire ctl_wr = host_wr & (a_addr_reg == `IBTS_OFS_CTRL);
  wire si_clr = ctl_wr & ~hwdata[`IBTS_CTL_SI];
  assign hreadyout = ~rd_first;
  assign hresp = 1'b0;
  assign hrdata = (rd_wait_reg & data_rd) ? {24'h000000, mem_rdata} : hrdata_reg;
  assign int_n = ~si_reg;

  // Open-drain pins only ever pull low.
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = ~scl_low_reg;
  assign sda_oe_n = ~sda_low_reg;

  // Line events, taken from the previous sample since pins are synchronous.
  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start_det = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_det = scl_in & scl_q & ~sda_q & sda_in;
  wire [6:0] cnt_inc = cnt_reg + 7'h01;
  wire byte_done = (state_reg == ST_BIT) & scl_fall & (bitcnt_reg == 4'h8);
  wire eng_we = byte_done & master_reg & rxm_reg & ~tx_reg;
  wire own_hit = aa_reg & (shift_reg[7:1] == own_reg[7:1]);
  wire gc_hit = own_reg[`IBTS_OWN_GC] & (shift_reg == 8'h00);
  wire last_rx = (cnt_inc == bc_reg) & lb_reg;

  // Received bytes take priority over host loads on the write port.
  ibts_buffer_mem #(
    .WIDTH(8),
    .DEPTH(BUF_DEPTH),
    .AW(PTR_W)
  ) u_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .we(eng_we | data_wr),
    .waddr(eng_we ? eptr_reg : hptr_reg),
    .wdata(eng_we ? shift_reg : hwdata[7:0]),
    .raddr(data_rd ? hptr_reg : eptr_reg),
    .rdata(mem_rdata)
  );

  // Address phase capture and read data register.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_valid_reg <= 1'b0;
      a_write_reg <= 1'b0;
      a_addr_reg <= 8'h00;
      rd_wait_reg <= 1'b0;
      hrdata_reg <= 32'h00000000;
    end else begin
      rd_wait_reg <= rd_first;
      if (hready) begin
        a_valid_reg <= hsel & htrans[1];
        a_write_reg <= hwrite;
        a_addr_reg <= haddr[7:0];
      end
      if (rd_first) begin
        case (a_addr_reg)
          `IBTS_OFS_STATUS: hrdata_reg <= {24'h000000, status_reg};
          `IBTS_OFS_COUNT: hrdata_reg <= {24'h000000, lb_reg, bc_reg};
          `IBTS_OFS_CTRL: hrdata_reg <= {24'h000000, aa_reg, 1'b0, sta_reg, sto_reg,
                                         si_reg, 2'b00, mode_reg};
          `IBTS_OFS_OWNADR: hrdata_reg <= {24'h000000, own_reg};
          default: hrdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  // Register file and serial engine. Engine updates come after host writes,
  // so a status posted in the cycle of a flag clear keeps the flag set.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= `IBTS_RST_STATUS;
      own_reg <= `IBTS_RST_OWNADR;
      {aa_reg, sta_reg, sto_reg, mode_reg} <= 4'h0;
      {lb_reg, bc_reg} <= `IBTS_RST_COUNT;
      si_reg <= 1'b0;
      hptr_reg <= {PTR_W{1'b0}};
      eptr_reg <= {PTR_W{1'b0}};
      cnt_reg <= 7'h00;
      state_reg <= ST_IDLE;
      bitcnt_reg <= 4'h0;
      ph_reg <= 2'b00;
      tmr_reg <= 16'h0000;
      shift_reg <= 8'h00;
      {nack_reg, sda_low_reg, scl_low_reg, master_reg, tx_reg} <= 5'h00;
      {addr_ph_reg, arb_lost_reg, rxm_reg, drop_reg, rep_reg} <= 5'h00;
      {busy_reg, scl_q, sda_q} <= 3'b011;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (start_det) begin
        busy_reg <= 1'b1;
      end else if (stop_det) begin
        busy_reg <= 1'b0;
      end
      if (tmr_reg != 16'h0000) begin
        tmr_reg <= tmr_reg - 16'h0001;
      end
      // Host side register writes and buffer pointer.
      if (host_wr & (a_addr_reg == `IBTS_OFS_COUNT)) begin
        {lb_reg, bc_reg} <= hwdata[7:0];
      end
      if (host_wr & (a_addr_reg == `IBTS_OFS_OWNADR)) begin
        own_reg <= hwdata[7:0];
      end
      if (ctl_wr) begin
        aa_reg <= hwdata[`IBTS_CTL_AA];
        sta_reg <= hwdata[`IBTS_CTL_STA];
        sto_reg <= hwdata[`IBTS_CTL_STO];
        mode_reg <= hwdata[`IBTS_CTL_MODE];
        hptr_reg <= {PTR_W{1'b0}};
      end else if (data_wr | (data_rd & rd_wait_reg)) begin
        hptr_reg <= ptr_inc(hptr_reg);
      end
      if (si_clr) begin
        si_reg <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          master_reg <= 1'b0;
          sda_low_reg <= 1'b0;
          scl_low_reg <= 1'b0;
          if (start_det) begin
            // Someone else's START: follow the address byte as a slave.
            state_reg <= ST_BIT;
            tx_reg <= 1'b0;
            rxm_reg <= 1'b0;
            addr_ph_reg <= 1'b1;
            bitcnt_reg <= 4'h0;
          end else if (sta_reg & ~busy_reg) begin
            state_reg <= ST_MSTART;
            master_reg <= 1'b1;
            rep_reg <= 1'b0;
            ph_reg <= 2'b00;
            tmr_reg <= HALF_LD;
          end
        end
        ST_MSTART: begin
          // Release data, then clock, then pull data low with clock high.
          case (ph_reg)
            2'b00: begin
              sda_low_reg <= 1'b0;
              if (tmr_reg == 16'h0000) begin
                scl_low_reg <= 1'b0;
                ph_reg <= 2'b01;
                tmr_reg <= HALF_LD;
              end
            end
            2'b01: begin
              if ((tmr_reg == 16'h0000) & scl_in & sda_in) begin
                sda_low_reg <= 1'b1;
                ph_reg <= 2'b10;
                tmr_reg <= HALF_LD;
              end
            end
            default: begin
              if (tmr_reg == 16'h0000) begin
                scl_low_reg <= 1'b1;
                sta_reg <= 1'b0;
                rxm_reg <= 1'b0;
                status_reg <= rep_reg ? `IBTS_ST_RSTART : `IBTS_ST_START;
                si_reg <= 1'b1;
                state_reg <= ST_WAIT;
              end
            end
          endcase
        end
        ST_WAIT: begin
          // The clock stays as entered; a master keeps it low meanwhile.
          if (si_clr) begin
            if (master_reg) begin
              if (hwdata[`IBTS_CTL_STO]) begin
                state_reg <= ST_MSTOP;
                ph_reg <= 2'b00;
                tmr_reg <= HALF_LD;
              end else if (hwdata[`IBTS_CTL_STA]) begin
                state_reg <= ST_MSTART;
                rep_reg <= 1'b1;
                ph_reg <= 2'b00;
                tmr_reg <= HALF_LD;
              end else if ((status_reg == `IBTS_ST_START) |
                           (status_reg == `IBTS_ST_RSTART)) begin
                addr_ph_reg <= 1'b1;
                tx_reg <= 1'b1;
                eptr_reg <= {PTR_W{1'b0}};
                cnt_reg <= 7'h00;
                state_reg <= ST_LD1;
              end else if ((status_reg == `IBTS_ST_MT_AACK) |
                           (status_reg == `IBTS_ST_MT_DACK)) begin
                addr_ph_reg <= 1'b0;
                eptr_reg <= {PTR_W{1'b0}};
                cnt_reg <= 7'h00;
                state_reg <= ST_LD1;
              end else if (status_reg == `IBTS_ST_MR_ACK) begin
                eptr_reg <= {PTR_W{1'b0}};
                cnt_reg <= 7'h00;
                bitcnt_reg <= 4'h0;
                sda_low_reg <= 1'b0;
                tmr_reg <= HALF_LD;
                state_reg <= ST_BIT;
              end
            end else if ((status_reg == `IBTS_ST_ST_OWN) | (status_reg == `IBTS_ST_ST_ARB) |
                         (status_reg == `IBTS_ST_ST_ACK)) begin
              drop_reg <= ~hwdata[`IBTS_CTL_AA];
              tx_reg <= 1'b1;
              eptr_reg <= {PTR_W{1'b0}};
              cnt_reg <= 7'h00;
              state_reg <= ST_LD1;
            end else begin
              scl_low_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_LD1: begin
          state_reg <= ST_LD2;
        end
        ST_LD2: begin
          // Load whatever the buffer holds, loaded by the host or not.
          shift_reg <= mem_rdata;
          sda_low_reg <= ~mem_rdata[7];
          bitcnt_reg <= 4'h0;
          state_reg <= ST_BIT;
          if (master_reg) begin
            tmr_reg <= HALF_LD;
          end else begin
            scl_low_reg <= 1'b0;
          end
        end
        ST_BIT: begin
          // Master clock generation; a low clock from others stalls the timer.
          if (master_reg) begin
            if (scl_low_reg & (tmr_reg == 16'h0000)) begin
              scl_low_reg <= 1'b0;
              tmr_reg <= HALF_LD;
            end else if (~scl_low_reg & ~scl_in) begin
              tmr_reg <= HALF_LD;
            end else if (~scl_low_reg & (tmr_reg == 16'h0000)) begin
              scl_low_reg <= 1'b1;
              tmr_reg <= HALF_LD;
            end
          end
          if (scl_rise) begin
            if (bitcnt_reg == 4'h8) begin
              nack_reg <= sda_in;
            end else begin
              shift_reg <= {shift_reg[6:0], sda_in};
              if (master_reg & tx_reg & ~sda_low_reg & ~sda_in) begin
                // Lost arbitration: drop off the bus, keep decoding the address.
                master_reg <= 1'b0;
                tx_reg <= 1'b0;
                scl_low_reg <= 1'b0;
                arb_lost_reg <= 1'b1;
                if (~addr_ph_reg) begin
                  status_reg <= `IBTS_ST_ARB_LOST;
                  si_reg <= 1'b1;
                  state_reg <= ST_IDLE;
                end
              end
            end
          end
          if (scl_fall & (bitcnt_reg < 4'h7)) begin
            bitcnt_reg <= bitcnt_reg + 4'h1;
            sda_low_reg <= tx_reg & ~shift_reg[7];
          end else if (scl_fall & (bitcnt_reg == 4'h7)) begin
            // Acknowledge slot: who drives it depends on the role.
            bitcnt_reg <= 4'h8;
            if (~master_reg & addr_ph_reg) begin
              sda_low_reg <= (own_hit & shift_reg[0]) | own_hit | gc_hit;
            end else if (master_reg & ~tx_reg) begin
              sda_low_reg <= ~last_rx;
            end else begin
              sda_low_reg <= 1'b0;
            end
          end else if (byte_done) begin
            bitcnt_reg <= 4'h0;
            sda_low_reg <= 1'b0;
            if (~master_reg & addr_ph_reg) begin
              arb_lost_reg <= 1'b0;
              addr_ph_reg <= 1'b0;
              if (sda_low_reg) begin
                si_reg <= 1'b1;
                scl_low_reg <= 1'b1;
                state_reg <= ST_WAIT;
                if (shift_reg[0]) begin
                  status_reg <= arb_lost_reg ? `IBTS_ST_ST_ARB : `IBTS_ST_ST_OWN;
                end else begin
                  status_reg <= gc_hit ? `IBTS_ST_SR_GC : `IBTS_ST_SR_OWN;
                end
              end else begin
                state_reg <= ST_IDLE;
                if (arb_lost_reg) begin
                  status_reg <= `IBTS_ST_ARB_LOST;
                  si_reg <= 1'b1;
                end
              end
            end else if (tx_reg) begin
              eptr_reg <= ptr_inc(eptr_reg);
              cnt_reg <= cnt_inc;
              addr_ph_reg <= 1'b0;
              if (nack_reg) begin
                bc_reg <= cnt_inc;
                si_reg <= 1'b1;
                state_reg <= ST_WAIT;
                if (master_reg) begin
                  scl_low_reg <= 1'b1;
                  status_reg <= ~addr_ph_reg ? `IBTS_ST_MT_DNACK :
                                shift_reg[0] ? `IBTS_ST_MR_ANACK : `IBTS_ST_MT_ANACK;
                end else begin
                  scl_low_reg <= 1'b0;
                  status_reg <= `IBTS_ST_ST_NACK;
                end
              end else if (master_reg & addr_ph_reg & shift_reg[0]) begin
                // Address with read acknowledged: straight into reception.
                tx_reg <= 1'b0;
                rxm_reg <= 1'b1;
                cnt_reg <= 7'h00;
                eptr_reg <= {PTR_W{1'b0}};
              end else if (cnt_inc == bc_reg) begin
                bc_reg <= cnt_inc;
                si_reg <= 1'b1;
                state_reg <= ST_WAIT;
                scl_low_reg <= master_reg | ~drop_reg;
                if (master_reg) begin
                  status_reg <= addr_ph_reg ? `IBTS_ST_MT_AACK : `IBTS_ST_MT_DACK;
                end else begin
                  status_reg <= drop_reg ? `IBTS_ST_ST_LAST : `IBTS_ST_ST_ACK;
                end
              end else begin
                state_reg <= ST_LD1;
                scl_low_reg <= 1'b1;
              end
            end else if (master_reg) begin
              eptr_reg <= ptr_inc(eptr_reg);
              cnt_reg <= cnt_inc;
              if (cnt_inc == bc_reg) begin
                bc_reg <= cnt_inc;
                status_reg <= sda_low_reg ? `IBTS_ST_MR_ACK : `IBTS_ST_MR_NACK;
                si_reg <= 1'b1;
                scl_low_reg <= 1'b1;
                state_reg <= ST_WAIT;
              end
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_MSTOP: begin
          // Data low, release clock, then release data with clock high.
          case (ph_reg)
            2'b00: begin
              sda_low_reg <= 1'b1;
              if (tmr_reg == 16'h0000) begin
                scl_low_reg <= 1'b0;
                ph_reg <= 2'b01;
                tmr_reg <= HALF_LD;
              end
            end
            2'b01: begin
              if ((tmr_reg == 16'h0000) & scl_in) begin
                sda_low_reg <= 1'b0;
                ph_reg <= 2'b10;
                tmr_reg <= HALF_LD;
              end
            end
            default: begin
              if (tmr_reg == 16'h0000) begin
                status_reg <= `IBTS_ST_IDLE;
                sto_reg <= 1'b0;
                master_reg <= 1'b0;
                state_reg <= ST_IDLE;
              end
            end
          endcase
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
      // A STOP from another master ends any slave activity at once.
      if (~master_reg & stop_det & (state_reg != ST_IDLE)) begin
        state_reg <= ST_IDLE;
        scl_low_reg <= 1'b0;
        sda_low_reg <= 1'b0;
      end
    end
  end

endmodule

// ### tb/ibts_core_properties.sv
// Purpose: Bus and pin properties of the sequencer core.
// Assumes: Bound to ibts_core; one clock domain.
// Notes: The flag is seen only through int_n.
module ibts_core_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic int_n,
  input wire logic scl_out,
  input wire logic sda_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wctl_reg;
  // Only the data phase of a control write may release the interrupt.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wctl_reg <= 1'b0;
    else wctl_reg <= hsel && htrans[1] && hready && hwrite && (haddr[7:0] == 8'h0c);
  end
  sequence s_rd;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_wr;
    hsel && htrans[1] && hready && hwrite;
  endsequence
  a_read_wait: assert property (s_rd |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_fast: assert property (s_wr |=> hreadyout) else $error("write stalled");
  a_read_upper: assert property (s_rd |=> ##1 hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_zero: assert property ((s_rd ##0 haddr[7:0] == 8'h14) |=> ##1 hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  a_irq_release: assert property ($rose(int_n) |-> $past(wctl_reg))
    else $error("interrupt released without control write");
  a_irq_stands: assert property (!int_n && !wctl_reg |=> !int_n)
    else $error("interrupt dropped by itself");
  a_lines_open: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("line driven high");
endmodule

bind ibts_core ibts_core_properties chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .int_n(int_n), .scl_out(scl_out), .sda_out(sda_out));

// ### tb/ibts_i2c_peer.sv
// Purpose: Behavioural slave receiver on the far side of the link.
// Assumes: Released lines read high through the bus pull-up.
// Notes: Acknowledges every byte; a STOP ends the session.
module ibts_i2c_peer (
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe_n,
  output logic [7:0] first_byte,
  output logic [7:0] last_byte,
  output int byte_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  // Shift each byte MSB first, then pull the ninth bit low for the acknowledge.
  initial begin
    sda_oe_n = 1'b1;
    byte_cnt = 0;
    @(negedge sda iff scl === 1'b1);
    forever begin
      fork
        forever begin
          repeat (8) @(posedge scl) sh = {sh[6:0], sda};
          @(negedge scl) sda_oe_n = 1'b0;
          if (byte_cnt == 0) first_byte = sh;
          last_byte = sh;
          byte_cnt++;
          @(negedge scl) sda_oe_n = 1'b1;
        end
        // Any data change with the clock high is a repeated START or a STOP.
        @(sda iff scl === 1'b1);
      join_any
      disable fork;
      if (sda === 1'b1) @(negedge sda iff scl === 1'b1);
    end
  end
endmodule

// ### tb/test_i2c_buffered_transfer_sequencer.sv
// Purpose: Self-checking bench of the buffered sequencer core.
// Assumes: One slave on the bus; the peer acknowledges all bytes.
// Notes: SCL half period shortened to three clocks.
module test_i2c_buffered_transfer_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, int_n, peer_oe_n;
  logic scl_out, sda_out, scl_oe_n, sda_oe_n;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [7:0] first_b, last_b;
  int errors, cmp_count, nb, i;
  // Wired-AND of the open-drain lines with a pull-up.
  wire scl = scl_oe_n;
  wire sda = sda_oe_n & peer_oe_n;
  ibts_core #(.HALF_CYC(3)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .int_n(int_n), .scl_in(scl),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n));
  ibts_i2c_peer peer (.scl(scl), .sda(sda), .sda_oe_n(peer_oe_n), .first_byte(first_b),
    .last_byte(last_b), .byte_cnt(nb));
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // One single transfer; waits on hready in both phases, read data lands in rd.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  // Steps one edge first, so a flag cleared at this very edge is not taken as set.
  task wait_irq;
    @(posedge hclk);
    for (i = 0; i < 3000 && int_n !== 1'b0; i++) @(posedge hclk);
  endtask
  task t_reset;
    `CHK("int_n", 1'b1, int_n)
    bus(0, 8'h00, 0);
    `CHK("status", 32'hf8, rd)
    bus(0, 8'h14, 0);
    `CHK("unmapped", 32'h0, rd)
  endtask
  // Sixty-nine pushes; the last must land on location zero.
  task t_wrap;
    bus(1, 8'h0c, 32'h01);
    for (int k = 0; k < 69; k++) bus(1, 8'h04, k);
    bus(1, 8'h0c, 32'h01);
    bus(0, 8'h04, 0);
    `CHK("wrap", 32'd68, rd)
  endtask
  // Count of two with a surplus byte, then a chained one-byte batch.
  task t_mtx;
    bus(1, 8'h0c, 32'h01);
    bus(1, 8'h08, 32'h02);
    bus(1, 8'h04, 32'ha0);
    bus(1, 8'h04, 32'h55);
    bus(1, 8'h04, 32'h77);
    bus(1, 8'h0c, 32'h21);
    wait_irq;
    bus(0, 8'h00, 0);
    `CHK("start status", 32'h08, rd)
    bus(1, 8'h0c, 32'h01);
    @(negedge hclk);
    `CHK("irq clear", 1'b1, int_n)
    wait_irq;
    `CHK("done irq", 1'b0, int_n)
    bus(0, 8'h00, 0);
    `CHK("tx status", 32'h28, rd)
    bus(0, 8'h08, 0);
    `CHK("sent count", 7'd2, rd[6:0])
    `CHK("bytes", 2, nb)
    `CHK("address", 8'ha0, first_b)
    `CHK("data", 8'h55, last_b)
    bus(1, 8'h08, 32'h81);
    bus(1, 8'h04, 32'h3c);
    bus(1, 8'h0c, 32'h01);
    wait_irq;
    bus(0, 8'h00, 0);
    `CHK("chain status", 32'h28, rd)
    `CHK("chain data", 8'h3c, last_b)
    `CHK("chain bytes", 3, nb)
  endtask
  // Repeated START, address with read, then one byte closed by a NACK.
  task t_mrx;
    bus(1, 8'h08, 32'h81);
    bus(1, 8'h04, 32'ha1);
    bus(1, 8'h0c, 32'h21);
    wait_irq;
    bus(0, 8'h00, 0);
    `CHK("restart status", 32'h10, rd)
    bus(1, 8'h0c, 32'h01);
    wait_irq;
    bus(0, 8'h00, 0);
    `CHK("rx status", 32'h58, rd)
    bus(0, 8'h08, 0);
    `CHK("rx count", 32'h81, rd)
    bus(0, 8'h04, 0);
    `CHK("rx data", 32'hff, rd)
  endtask
  task t_stop;
    bus(1, 8'h0c, 32'h11);
    repeat (200) @(posedge hclk);
    `CHK("stop irq", 1'b1, int_n)
    `CHK("sda idle", 1'b1, sda)
    bus(0, 8'h00, 0);
    `CHK("stop status", 32'hf8, rd)
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // The whole run needs well under twenty thousand clocks.
  initial begin
    #(60000 * 50);
    errors++;
    end_sim;
  end
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hresetn = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_wrap;
    t_mtx;
    t_mrx;
    t_stop;
    end_sim;
  end
endmodule
